// ===== logic/rif_pkg.sv
/*
  Shared constants and carrier types of the interrupt request flag controller.
  Assumes a 32-bit APB slave with word-aligned registers and same-clock event sources.
*/
package rif_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_REQ_A   = 6'h06;
  localparam logic [5:0] IDX_REQ_B   = 6'h07;
  localparam logic [5:0] IDX_EN_A    = 6'h08;
  localparam logic [5:0] IDX_EN_B    = 6'h09;
  localparam logic [5:0] IDX_FIFO_WL = 6'h0c;

  // Field positions
  localparam int SET_SEL_BIT    = 7;
  localparam int HIGH_LEVEL_BIT = 6;
  localparam int LOW_LEVEL_BIT  = 5;
  localparam int CMD_DONE_BIT   = 4;
  localparam int TX_DONE_BIT    = 3;
  localparam int RX_DONE_BIT    = 2;
  localparam int ERROR_BIT      = 1;
  localparam int FRAME_BIT      = 0;
  localparam int COMBINED_BIT   = 6;
  localparam int CARD_BIT       = 5;
  localparam int INVERT_BIT     = 7;
  localparam int GATE_BIT       = 6;
  localparam int DRIVE_BIT      = 7;
  localparam int CAP_SEL_BIT    = 9;
  localparam int HIGH_LIVE_BIT  = 10;
  localparam int LOW_LIVE_BIT   = 11;

  // FIFO capacities: select one gives the small FIFO
  localparam logic [9:0] CAP_SMALL = 10'h0ff;
  localparam logic [9:0] CAP_LARGE = 10'h200;

  // Command field code of the idle command
  localparam logic [3:0] CMD_IDLE = 4'h0;

  // Events from same-clock sources
  typedef struct packed {
    logic       txDone;        // Last bit sent, pulse
    logic       rxEnd;         // End of incoming stream, pulse
    logic       frameStart;    // Start-of-frame or subcarrier seen, pulse
    logic       cardFound;     // Card detection found a card, pulse
    logic [4:0] timerUnder;    // Timer 4..0 underflow, pulses
    logic [4:0] errBits;       // Write, overflow, protocol, no-data, integrity errors, levels
    logic       cmdUnknown;    // Unknown command code started, pulse
    logic       hostIdleWrite; // Host wrote the idle command this cycle, pulse
    logic [3:0] cmdField;      // Current command field
    logic [9:0] fifoByteCount; // Current FIFO byte count
  } rif_evt_t;

  // Whole state of the controller
  typedef struct packed {
    logic [6:0]  reqA;
    logic [5:0]  reqB;
    logic        combined;
    logic [7:0]  enA;
    logic [7:0]  enB;
    logic [8:0]  waterLevel;
    logic        capSel;
    logic        hiPrev;
    logic        loPrev;
    logic [4:0]  errPrev;
    logic [3:0]  cmdPrev;
    logic [31:0] rdata;
    logic        ready;
    logic        slvErr;
    logic        irqOut;
    logic        irqOe;
  } rif_state_t;

  localparam rif_state_t STATE_RESET = '0;

endpackage

// ===== logic/rif_flag_ctrl.sv
/*
  Interrupt request flag controller: two request registers with set/clear
  selection, two enable registers, a combined request and the interrupt pin.
  Assumes an APB master on clk and event sources clocked by clk.
*/
// The APB interface to the registers is this design's own decision.
module rif_flag_ctrl #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Event sources
  input  rif_pkg::rif_evt_t     evtIn,
  // Interrupt pin
  output logic                  irqOut,
  output logic                  irqOe
);

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_check
    $error("ADDR_W must lie between 8 and 32");
  end

  rif_pkg::rif_state_t st_reg;
  rif_pkg::rif_state_t st_next;

  logic        setupPh;
  logic        accessPh;
  logic        wrReqA;
  logic        wrReqB;
  logic [6:0]  setA;
  logic [6:0]  clrA;
  logic [5:0]  setB;
  logic [5:0]  clrB;
  logic [6:0]  hwA;
  logic [5:0]  hwB;
  logic [9:0]  capacity;
  logic [9:0]  count;
  logic [9:0]  level;
  logic        hiLive;
  logic        loLive;
  logic        cmdDoneEvt;
  logic        pinReq;
  logic        pinLevel;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  function automatic logic [31:0] readMux(input logic [ADDR_W-1:0] a,
                                          input rif_pkg::rif_state_t s,
                                          input logic hi, input logic lo);
    readMux = 32'h0000_0000;
    if (hit(a, rif_pkg::IDX_REQ_A)) begin
      readMux[6:0] = s.reqA;
    end else if (hit(a, rif_pkg::IDX_REQ_B)) begin
      readMux[6:0] = {s.combined, s.reqB};
    end else if (hit(a, rif_pkg::IDX_EN_A)) begin
      readMux[7:0] = s.enA;
    end else if (hit(a, rif_pkg::IDX_EN_B)) begin
      readMux[7:0] = s.enB;
    end else if (hit(a, rif_pkg::IDX_FIFO_WL)) begin
      readMux[8:0] = s.waterLevel;
      readMux[rif_pkg::CAP_SEL_BIT]   = s.capSel;
      readMux[rif_pkg::HIGH_LIVE_BIT] = hi;
      readMux[rif_pkg::LOW_LIVE_BIT]  = lo;
    end
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, rif_pkg::IDX_REQ_A) | hit(a, rif_pkg::IDX_REQ_B) |
             hit(a, rif_pkg::IDX_EN_A) | hit(a, rif_pkg::IDX_EN_B) |
             hit(a, rif_pkg::IDX_FIFO_WL);
  endfunction

  always_comb begin
    st_next  = st_reg;
    setupPh  = psel & ~penable;
    accessPh = psel & penable & st_reg.ready;
    wrReqA   = accessPh & pwrite & hit(paddr, rif_pkg::IDX_REQ_A);
    wrReqB   = accessPh & pwrite & hit(paddr, rif_pkg::IDX_REQ_B);

    // Small FIFO ignores the extension bits of count and level
    capacity = st_reg.capSel ? rif_pkg::CAP_SMALL : rif_pkg::CAP_LARGE;
    count    = st_reg.capSel ? {2'b00, evtIn.fifoByteCount[7:0]} : evtIn.fifoByteCount;
    level    = st_reg.capSel ? {2'b00, st_reg.waterLevel[7:0]} : {1'b0, st_reg.waterLevel};
    hiLive   = (capacity - count) <= level;
    loLive   = count <= level;

    // Host writing idle is not a self-termination
    cmdDoneEvt = ((st_reg.cmdPrev != rif_pkg::CMD_IDLE) &&
                  (evtIn.cmdField == rif_pkg::CMD_IDLE) &&
                  !evtIn.hostIdleWrite) ||
                 evtIn.cmdUnknown;

    hwA = '0;
    hwA[rif_pkg::HIGH_LEVEL_BIT] = hiLive & ~st_reg.hiPrev;
    hwA[rif_pkg::LOW_LEVEL_BIT]  = loLive & ~st_reg.loPrev;
    hwA[rif_pkg::CMD_DONE_BIT]   = cmdDoneEvt;
    hwA[rif_pkg::TX_DONE_BIT]    = evtIn.txDone;
    hwA[rif_pkg::RX_DONE_BIT]    = evtIn.rxEnd;
    hwA[rif_pkg::ERROR_BIT]      = |(evtIn.errBits & ~st_reg.errPrev);
    hwA[rif_pkg::FRAME_BIT]      = evtIn.frameStart;
    hwB = {evtIn.cardFound, evtIn.timerUnder};

    // Written ones set or clear depending on the select bit
    setA = (wrReqA &  pwdata[rif_pkg::SET_SEL_BIT]) ? pwdata[6:0] : 7'h00;
    clrA = (wrReqA & ~pwdata[rif_pkg::SET_SEL_BIT]) ? pwdata[6:0] : 7'h00;
    setB = (wrReqB &  pwdata[rif_pkg::SET_SEL_BIT]) ? pwdata[5:0] : 6'h00;
    clrB = (wrReqB & ~pwdata[rif_pkg::SET_SEL_BIT]) ? pwdata[5:0] : 6'h00;

    // Hardware set wins over a clear in the same cycle
    st_next.reqA = (st_reg.reqA & ~clrA) | setA | hwA;
    st_next.reqB = (st_reg.reqB & ~clrB) | setB | hwB;

    st_next.hiPrev  = hiLive;
    st_next.loPrev  = loLive;
    st_next.errPrev = evtIn.errBits;
    st_next.cmdPrev = evtIn.cmdField;

    if (accessPh & pwrite & hit(paddr, rif_pkg::IDX_EN_A)) begin
      st_next.enA = pwdata[7:0];
    end
    if (accessPh & pwrite & hit(paddr, rif_pkg::IDX_EN_B)) begin
      st_next.enB = pwdata[7:0];
    end
    if (accessPh & pwrite & hit(paddr, rif_pkg::IDX_FIFO_WL)) begin
      st_next.waterLevel = pwdata[8:0];
      st_next.capSel     = pwdata[rif_pkg::CAP_SEL_BIT];
    end

    st_next.combined = |(st_next.reqA & st_next.enA[6:0]) |
                       |(st_next.reqB & st_next.enB[5:0]);

    pinReq   = st_next.combined & st_next.enB[rif_pkg::GATE_BIT];
    pinLevel = pinReq ^ st_next.enA[rif_pkg::INVERT_BIT];
    st_next.irqOut = pinLevel;
    st_next.irqOe  = st_next.enB[rif_pkg::DRIVE_BIT] | pinReq;

    // No wait state: answer prepared in setup, presented in the first access cycle
    st_next.ready  = setupPh;
    st_next.slvErr = setupPh & ~mapped(paddr);
    st_next.rdata  = (setupPh & ~pwrite) ? readMux(paddr, st_reg, hiLive, loLive) : 32'h0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= rif_pkg::STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata  = st_reg.rdata;
  assign pready  = st_reg.ready;
  assign pslverr = st_reg.slvErr;
  assign irqOut  = st_reg.irqOut;
  assign irqOe   = st_reg.irqOe;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_req_a_set: assert property (
    wrReqA && pwdata[7] |=> ((st_reg.reqA & $past(pwdata[6:0])) == $past(pwdata[6:0])))
    else $error("first request set write lost");

  a_req_a_clear: assert property (
    wrReqA && !pwdata[7]
      |=> ((st_reg.reqA & $past(pwdata[6:0]) & ~$past(hwA)) == 7'h00))
    else $error("first request clear write failed");

  a_req_b_write: assert property (
    wrReqB |=> ($past(pwdata[7])
               ? ((st_reg.reqB & $past(pwdata[5:0])) == $past(pwdata[5:0]))
               : ((st_reg.reqB & $past(pwdata[5:0]) & ~$past(hwB)) == 6'h00)))
    else $error("second request write wrong");

  a_high_latch: assert property (
    hiLive && !st_reg.hiPrev |=> st_reg.reqA[6])
    else $error("high-level flag not latched");

  a_high_hold: assert property (
    st_reg.reqA[6] && !clrA[6] |=> st_reg.reqA[6])
    else $error("high-level flag dropped without clear");

  a_low_latch: assert property (
    loLive && !st_reg.loPrev |=> st_reg.reqA[5])
    else $error("low-level flag not latched");

  a_cmd_done: assert property (
    st_reg.cmdPrev != 4'h0 && evtIn.cmdField == 4'h0 && !evtIn.hostIdleWrite
      |=> st_reg.reqA[4])
    else $error("command done flag missing");

  a_cmd_unknown: assert property (
    evtIn.cmdUnknown |=> st_reg.reqA[4])
    else $error("unknown command did not flag");

  a_host_idle: assert property (
    evtIn.hostIdleWrite && !evtIn.cmdUnknown && !st_reg.reqA[4] && !setA[4]
      |=> !st_reg.reqA[4])
    else $error("host idle write set done flag");

  a_tx_rx_frame: assert property (
    evtIn.txDone || evtIn.rxEnd || evtIn.frameStart
      |=> ((st_reg.reqA[3] || !$past(evtIn.txDone)) &&
           (st_reg.reqA[2] || !$past(evtIn.rxEnd)) &&
           (st_reg.reqA[0] || !$past(evtIn.frameStart))))
    else $error("transfer event flag missing");

  a_error_sum: assert property (
    |(evtIn.errBits & ~st_reg.errPrev) |=> st_reg.reqA[1])
    else $error("error summary flag missing");

  a_card_timer: assert property (
    evtIn.cardFound || |evtIn.timerUnder
      |=> ((st_reg.reqB & $past(hwB)) == $past(hwB)))
    else $error("card or timer flag missing");

  a_combined_req: assert property (
    st_reg.combined == (|(st_reg.reqA & st_reg.enA[6:0]) | |(st_reg.reqB & st_reg.enB[5:0])))
    else $error("combined request mismatch");

  a_pin_gate: assert property (
    !st_reg.enB[6] |-> (irqOut == st_reg.enA[7]))
    else $error("gated pin shows a request");

  a_pin_level: assert property (
    st_reg.combined && st_reg.enB[6] |-> (irqOut == !st_reg.enA[7]))
    else $error("pin polarity wrong");

  a_drive_mode: assert property (
    irqOe == (st_reg.enB[7] || (st_reg.combined && st_reg.enB[6])))
    else $error("pin drive mode wrong");

  a_apb_answer: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("APB answer timing wrong");

  a_low_hold: assert property (
    st_reg.reqA[5] && !clrA[5] |=> st_reg.reqA[5])
    else $error("low-level flag dropped without clear");

  a_flag_a_hold: assert property (
    st_reg.reqA != 7'h00
      |=> ((st_reg.reqA & $past(st_reg.reqA & ~clrA)) == $past(st_reg.reqA & ~clrA)))
    else $error("first request flag lost");

  a_flag_b_hold: assert property (
    st_reg.reqB != 6'h00
      |=> ((st_reg.reqB & $past(st_reg.reqB & ~clrB)) == $past(st_reg.reqB & ~clrB)))
    else $error("second request flag lost");

  a_flag_a_source: assert property (
    (~st_reg.reqA & ~setA & ~hwA) != 7'h00
      |=> ((st_reg.reqA & $past(~st_reg.reqA & ~setA & ~hwA)) == 7'h00))
    else $error("first request flag set without cause");

  a_flag_b_source: assert property (
    (~st_reg.reqB & ~setB & ~hwB) != 6'h00
      |=> ((st_reg.reqB & $past(~st_reg.reqB & ~setB & ~hwB)) == 6'h00))
    else $error("second request flag set without cause");

  a_reset_clear: assert property (
    $rose(reset_n) |-> (st_reg.reqA == 7'h00))
    else $error("first request not clear after reset");

  a_reset_pins: assert property (
    $rose(reset_n) |-> !irqOut && !irqOe && !pready && !pslverr && (prdata == 32'h0))
    else $error("outputs not idle after reset");

  a_read_bit7: assert property (
    pready && (hit(paddr, rif_pkg::IDX_REQ_A) || hit(paddr, rif_pkg::IDX_REQ_B))
      |-> !prdata[7])
    else $error("request register bit 7 reads one");

  a_read_req_a: assert property (
    pready && !pwrite && hit(paddr, rif_pkg::IDX_REQ_A)
      |-> (prdata[6:0] == $past(st_reg.reqA)))
    else $error("first request read wrong");

  a_read_req_b: assert property (
    pready && !pwrite && hit(paddr, rif_pkg::IDX_REQ_B)
      |-> (prdata[6:0] == {$past(st_reg.combined), $past(st_reg.reqB)}))
    else $error("second request read wrong");

  a_rdata_idle: assert property (
    !pready |-> (prdata == 32'h0))
    else $error("read data outside access cycle");

  a_unmapped_error: assert property (
    pready && !mapped(paddr)
      |-> pslverr && (prdata == 32'h0))
    else $error("unmapped access not refused");

  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("ready stands too long");

  a_ready_cause: assert property (
    pready |-> $past(psel && !penable))
    else $error("ready without setup");

  a_en_a_write: assert property (
    accessPh && pwrite && hit(paddr, rif_pkg::IDX_EN_A)
      |=> (st_reg.enA == $past(pwdata[7:0])))
    else $error("first enable write lost");

  a_en_b_write: assert property (
    accessPh && pwrite && hit(paddr, rif_pkg::IDX_EN_B)
      |=> (st_reg.enB == $past(pwdata[7:0])))
    else $error("second enable write lost");

  a_cfg_write: assert property (
    accessPh && pwrite && hit(paddr, rif_pkg::IDX_FIFO_WL)
      |=> (st_reg.waterLevel == $past(pwdata[8:0])) &&
          (st_reg.capSel == $past(pwdata[rif_pkg::CAP_SEL_BIT])))
    else $error("FIFO level write lost");

  a_en_a_stable: assert property (
    !(accessPh && pwrite && hit(paddr, rif_pkg::IDX_EN_A))
      |=> $stable(st_reg.enA))
    else $error("first enable changed without write");

  a_high_live: assert property (
    !st_reg.capSel |-> (hiLive ==
      ((rif_pkg::CAP_LARGE - evtIn.fifoByteCount) <= {1'b0, st_reg.waterLevel})))
    else $error("high live status wrong");

  a_low_live: assert property (
    !st_reg.capSel
      |-> (loLive == (evtIn.fifoByteCount <= {1'b0, st_reg.waterLevel})))
    else $error("low live status wrong");

  a_small_live: assert property (
    st_reg.capSel
      |-> (hiLive == ((rif_pkg::CAP_SMALL - {2'b00, evtIn.fifoByteCount[7:0]}) <=
                      {2'b00, st_reg.waterLevel[7:0]})) &&
          (loLive == (evtIn.fifoByteCount[7:0] <= st_reg.waterLevel[7:0])))
    else $error("small FIFO live status wrong");

  a_open_drain: assert property (
    !st_reg.enB[7] && irqOe |-> (irqOut == !st_reg.enA[7]))
    else $error("open-drain pin drives idle level");

  a_push_pull: assert property (
    st_reg.enB[7] |-> irqOe)
    else $error("push-pull pin not driven");

  a_combined_rise: assert property (
    !(accessPh && pwrite) &&
      (((hwA & st_reg.enA[6:0]) != 7'h00) || ((hwB & st_reg.enB[5:0]) != 6'h00))
      |=> st_reg.combined)
    else $error("enabled event raised no combined request");

endmodule // rif_flag_ctrl

// ===== verification/rif_host_model.sv
/*
  Host side of the interrupt pin: resolves the line level the host samples.
  Assumes a resistor pulls the released line to PULL_LEVEL.
*/
module rif_host_model #(
  parameter logic PULL_LEVEL = 1'h0
) (
  // Pin from the controller
  input  wire logic irqOut,
  input  wire logic irqOe,
  // Line as the host sees it
  output logic      pinLevel
);
  timeunit 1ns;
  timeprecision 1ns;

  // A released line falls back to the pull level, never to the last driven value
  assign pinLevel = irqOe ? irqOut : PULL_LEVEL;
endmodule // rif_host_model

// ===== verification/rif_flag_ctrl_tb.sv
/*
  Self-checking bench of the interrupt request flag controller.
  Assumes the APB slave answers with pready and a host model resolves the pin.
*/
module rif_flag_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [7:0] A_REQ_A = {rif_pkg::IDX_REQ_A, 2'h0};
  localparam logic [7:0] A_REQ_B = {rif_pkg::IDX_REQ_B, 2'h0};
  localparam logic [7:0] A_EN_A  = {rif_pkg::IDX_EN_A, 2'h0};
  localparam logic [7:0] A_EN_B  = {rif_pkg::IDX_EN_B, 2'h0};
  localparam logic [7:0] A_CFG   = {rif_pkg::IDX_FIFO_WL, 2'h0};

  logic              clk;
  logic              reset_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  rif_pkg::rif_evt_t evtIn;
  logic              irqOut;
  logic              irqOe;
  logic              pinLevel;
  int                bad_count;
  int                n_tests;
  int                cycles;

  rif_flag_ctrl #(.ADDR_W(8)) dut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evtIn(evtIn), .irqOut(irqOut), .irqOe(irqOe));

  rif_host_model #(.PULL_LEVEL(1'h0)) host (.irqOut(irqOut), .irqOe(irqOe),
    .pinLevel(pinLevel));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  task automatic complete_run;
    $display("Mismatches %0d, comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      $display("BAD %0t timeout", $time);
      complete_run();
    end
  end

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One transfer; request held until the edge at which pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic e);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    d = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    // One idle edge keeps the next setup out of this time step
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'h1, a, v, d, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ee = 1'h0);
    logic [31:0] d;
    logic        e;
    apb(1'h0, a, 32'h0, d, e);
    chk({e, d}, {ee, exp});
  endtask

  // Ends the pulse-type events after one cycle
  task automatic tick;
    @(posedge clk);
    evtIn.txDone        <= 1'h0;
    evtIn.rxEnd         <= 1'h0;
    evtIn.frameStart    <= 1'h0;
    evtIn.cardFound     <= 1'h0;
    evtIn.timerUnder    <= 5'h00;
    evtIn.cmdUnknown    <= 1'h0;
    evtIn.hostIdleWrite <= 1'h0;
  endtask

  task automatic pin(input logic o, input logic oe, input logic lvl);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({30'h0, irqOut, irqOe, pinLevel}, {30'h0, o, oe, lvl});
    @(posedge clk);
  endtask

  task automatic t_reset;
    rd(A_REQ_A, 32'h0);
    rd(A_REQ_B, 32'h0);
    rd(A_EN_A, 32'h0);
    rd(A_EN_B, 32'h0);
    rd(8'h3c, 32'h0, 1'h1);
  endtask

  task automatic t_write;
    wr(A_REQ_A, 32'hff);
    rd(A_REQ_A, 32'h7f);
    wr(A_REQ_A, 32'h0a);
    rd(A_REQ_A, 32'h75);
    wr(A_REQ_A, 32'h7f);
    rd(A_REQ_A, 32'h00);
    wr(A_REQ_B, 32'hbf);
    rd(A_REQ_B, 32'h3f);
    wr(A_REQ_B, 32'h15);
    rd(A_REQ_B, 32'h2a);
    wr(A_REQ_B, 32'h3f);
    rd(A_REQ_B, 32'h00);
  endtask

  task automatic t_events;
    evtIn.txDone <= 1'h1;
    tick();
    rd(A_REQ_A, 32'h08);
    evtIn.rxEnd <= 1'h1;
    tick();
    rd(A_REQ_A, 32'h0c);
    evtIn.frameStart <= 1'h1;
    tick();
    rd(A_REQ_A, 32'h0d);
    wr(A_REQ_A, 32'h0d);
    for (int n = 0; n < 5; n++) begin
      evtIn.errBits <= 5'h01 << n;
      tick();
      rd(A_REQ_A, 32'h02);
      evtIn.errBits <= 5'h00;
      wr(A_REQ_A, 32'h02);
    end
    evtIn.cardFound <= 1'h1;
    tick();
    rd(A_REQ_B, 32'h20);
    for (int n = 0; n < 5; n++) begin
      evtIn.timerUnder <= 5'h01 << n;
      tick();
      rd(A_REQ_B, 32'h20 | ((32'h2 << n) - 32'h1));
    end
    wr(A_REQ_B, 32'h3f);
  endtask

  task automatic t_command;
    evtIn.cmdField <= 4'h3;
    tick();
    evtIn.cmdField <= rif_pkg::CMD_IDLE;
    tick();
    rd(A_REQ_A, 32'h10);
    wr(A_REQ_A, 32'h10);
    evtIn.cmdField <= 4'h3;
    tick();
    evtIn.cmdField      <= rif_pkg::CMD_IDLE;
    evtIn.hostIdleWrite <= 1'h1;
    tick();
    rd(A_REQ_A, 32'h00);
    evtIn.cmdUnknown <= 1'h1;
    tick();
    rd(A_REQ_A, 32'h10);
    wr(A_REQ_A, 32'h10);
  endtask

  task automatic t_levels;
    wr(A_CFG, 32'h010);
    tick();
    rd(A_REQ_A, 32'h20);
    rd(A_CFG, 32'h810);
    evtIn.fifoByteCount <= 10'h020;
    tick();
    rd(A_CFG, 32'h010);
    rd(A_REQ_A, 32'h20);
    evtIn.fifoByteCount <= 10'h1f0;
    tick();
    rd(A_CFG, 32'h410);
    evtIn.fifoByteCount <= 10'h1ef;
    tick();
    rd(A_CFG, 32'h010);
    rd(A_REQ_A, 32'h60);
    wr(A_REQ_A, 32'h60);
    rd(A_REQ_A, 32'h00);
    // Small FIFO: capacity 255, only the low count and level bits count
    wr(A_CFG, 32'h210);
    rd(A_CFG, 32'h610);
    rd(A_REQ_A, 32'h40);
    wr(A_CFG, 32'h010);
    wr(A_REQ_A, 32'h40);
    rd(A_REQ_A, 32'h00);
  endtask

  task automatic t_pin;
    wr(A_EN_A, 32'h08);
    evtIn.txDone <= 1'h1;
    tick();
    rd(A_REQ_B, 32'h40);
    pin(1'h0, 1'h0, 1'h0);
    wr(A_EN_B, 32'h40);
    pin(1'h1, 1'h1, 1'h1);
    wr(A_EN_A, 32'h88);
    pin(1'h0, 1'h1, 1'h0);
    wr(A_EN_A, 32'h80);
    rd(A_REQ_B, 32'h00);
    pin(1'h1, 1'h0, 1'h0);
    wr(A_EN_B, 32'hc2);
    pin(1'h1, 1'h1, 1'h1);
    evtIn.timerUnder <= 5'h02;
    tick();
    rd(A_REQ_B, 32'h42);
    pin(1'h0, 1'h1, 1'h0);
    wr(A_REQ_B, 32'h02);
    wr(A_REQ_A, 32'h08);
    rd(A_REQ_B, 32'h00);
    pin(1'h1, 1'h1, 1'h1);
  endtask

  initial begin
    bad_count = 0;
    n_tests   = 0;
    reset_n   = 1'h0;
    psel      = 1'h0;
    penable   = 1'h0;
    pwrite    = 1'h0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    evtIn     = '0;
    // Count above the zero water level keeps both live alerts low at release
    evtIn.fifoByteCount = 10'h001;
    repeat (16) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    t_reset();
    t_write();
    t_events();
    t_command();
    t_levels();
    t_pin();
    complete_run();
  end
endmodule // rif_flag_ctrl_tb
